// ==== design/spm_gpio_regs.svh ====
/*
 register offsets, field positions and reset values of the pin mux / gpio block.
 assumes a 16-bit word-addressed data space with register access in one cycle.
*/
`ifndef SPM_GPIO_REGS_SVH
`define SPM_GPIO_REGS_SVH
`define SPM_ADDR_SEL_A 16'h7090
`define SPM_ADDR_SEL_B 16'h7092
`define SPM_ADDR_SEL_C 16'h7094
`define SPM_ADDR_PORT_E 16'h7095
`define SPM_ADDR_PORT_F 16'h7096
`define SPM_ADDR_PORT_A 16'h7098
`define SPM_ADDR_PORT_B 16'h709a
`define SPM_ADDR_PORT_C 16'h709c
`define SPM_ADDR_PORT_D 16'h709e
`define SPM_RST_SEL_A 16'h0000
`define SPM_RST_SEL_B 16'hfe03
`define SPM_RST_SEL_C 16'h0001
`define SPM_MASK_SEL_C 16'h3fff
`define SPM_MASK_PORT_F 16'h3f3f
`define SPM_MASK_PORT_FULL 16'hffff
`define SPM_RST_PORT 16'h0000
`define SPM_DIR_LSB 8
`endif

// ==== design/spm_gpio_pkg.sv ====
/*
 types shared by the pin mux / gpio block.
 assumes spm_gpio_regs.svh for the numbers.
*/
package spm_gpio_pkg;
	typedef enum logic [3:0] {
		SPM_SEL_A = 4'h0,
		SPM_SEL_B = 4'h1,
		SPM_SEL_C = 4'h3,
		SPM_PORT_E = 4'h2,
		SPM_PORT_F = 4'h6,
		SPM_PORT_A = 4'h7,
		SPM_PORT_B = 4'h5,
		SPM_PORT_C = 4'h4,
		SPM_PORT_D = 4'hc,
		SPM_NONE = 4'hf
	} spm_reg_e;
	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] val;
	} spm_port_s;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} spm_bus_s;
endpackage : spm_gpio_pkg

// ==== design/spm_gpio.sv ====
/*
 shared pin mux and gpio ports a to f with their data-space registers.
 assumes a single-cycle data-space access from the cpu, pins synchronous to i_core_clk.
*/
// Functional notes
// - select c bits 0-7 pick port e pins, 8-13 port f; set means peripheral.
// - port e register: data in bits 0-7, direction in bits 8-15.
// - port f register: data bits 0-5, direction bits 8-13.
// - direction 0 is input, 1 is output driven from data bit.
// - software write to data bit of an output sets the driven level.
// - reading data bit of an input returns the live pin level.
// - data and direction act only when mux selects gpio.
// - reset: port e pin 0 peripheral, other e and f select bits zero.
// - port c pin 0 resets to strobe function; software clears select b bit 0.
// - select registers decode at 7090h, 7092h, 7094h.
// - ports a to d decode at 7098h, 709ah, 709ch, 709eh.
`timescale 1ns/1ns
`include "spm_gpio_regs.svh"
module spm_gpio
	import spm_gpio_pkg::*;
#(
	parameter int NUM_PORTS = 6
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire spm_bus_s i_bus,
	output logic [15:0] o_rdata,
	input wire logic [NUM_PORTS*8-1:0] i_pin,
	output logic [NUM_PORTS*8-1:0] o_pin,
	output logic [NUM_PORTS*8-1:0] o_pin_oe,
	input wire logic [NUM_PORTS*8-1:0] i_periph_out,
	input wire logic [NUM_PORTS*8-1:0] i_periph_oe,
	output logic [NUM_PORTS*8-1:0] o_periph_in
);
	// select map is fixed to six ports
	if (NUM_PORTS != 6) begin : g_bad_ports
		$error("spm_gpio serves exactly six ports");
	end

	// port order in vectors: a,b,c,d,e,f
	function automatic spm_reg_e decode(input logic [15:0] addr);
		case (addr)
			`SPM_ADDR_SEL_A: decode = SPM_SEL_A;
			`SPM_ADDR_SEL_B: decode = SPM_SEL_B;
			`SPM_ADDR_SEL_C: decode = SPM_SEL_C;
			`SPM_ADDR_PORT_E: decode = SPM_PORT_E;
			`SPM_ADDR_PORT_F: decode = SPM_PORT_F;
			`SPM_ADDR_PORT_A: decode = SPM_PORT_A;
			`SPM_ADDR_PORT_B: decode = SPM_PORT_B;
			`SPM_ADDR_PORT_C: decode = SPM_PORT_C;
			`SPM_ADDR_PORT_D: decode = SPM_PORT_D;
			default: decode = SPM_NONE;
		endcase
	endfunction : decode

	function automatic int port_idx(input spm_reg_e r);
		case (r)
			SPM_PORT_A: port_idx = 0;
			SPM_PORT_B: port_idx = 1;
			SPM_PORT_C: port_idx = 2;
			SPM_PORT_D: port_idx = 3;
			SPM_PORT_E: port_idx = 4;
			SPM_PORT_F: port_idx = 5;
			default: port_idx = 6;
		endcase
	endfunction : port_idx

	logic [15:0] sel_a_r, sel_b_r, sel_c_r;
	logic [15:0] sel_a_nxt, sel_b_nxt, sel_c_nxt;
	spm_port_s port_r [NUM_PORTS];
	spm_port_s port_nxt [NUM_PORTS];
	logic [15:0] rdata_nxt;
	logic [15:0] port_mask [NUM_PORTS];
	logic [NUM_PORTS*8-1:0] mux_sel;
	logic [NUM_PORTS*8-1:0] gpio_oe;
	logic [NUM_PORTS*8-1:0] gpio_val;
	spm_reg_e acc;
	int pi;

	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			port_mask[p] = (p == 5) ? `SPM_MASK_PORT_F : `SPM_MASK_PORT_FULL;
		end
	end

	assign acc = decode(i_bus.addr);
	assign pi = port_idx(acc);
	// mux select in port order a..f
	assign mux_sel = {2'h0, sel_c_r[13:0], sel_b_r, sel_a_r};

	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			gpio_oe[p*8 +: 8] = port_r[p].dir;
			gpio_val[p*8 +: 8] = port_r[p].val;
		end
	end

	// pin drive: peripheral when selected, gpio otherwise
	always_comb begin
		for (int b = 0; b < NUM_PORTS*8; b++) begin
			o_pin[b] = mux_sel[b] ? i_periph_out[b] : gpio_val[b];
			o_pin_oe[b] = mux_sel[b] ? i_periph_oe[b] : gpio_oe[b];
			o_periph_in[b] = mux_sel[b] & i_pin[b];
		end
		o_pin[47:46] = 2'h0;
		o_pin_oe[47:46] = 2'h0;
		o_periph_in[47:46] = 2'h0;
	end

	always_comb begin
		sel_a_nxt = sel_a_r;
		sel_b_nxt = sel_b_r;
		sel_c_nxt = sel_c_r;
		rdata_nxt = 16'h0000;
		for (int p = 0; p < NUM_PORTS; p++) begin
			port_nxt[p] = port_r[p];
			// inputs track the masked pin in the data register; reads of inputs take i_pin directly
			for (int b = 0; b < 8; b++) begin
				if (!port_r[p].dir[b]) begin
					port_nxt[p].val[b] = i_pin[p*8+b] & port_mask[p][b];
				end
			end
		end
		if (i_bus.wr) begin
			case (acc)
				SPM_SEL_A: sel_a_nxt = i_bus.wdata;
				SPM_SEL_B: sel_b_nxt = i_bus.wdata;
				SPM_SEL_C: sel_c_nxt = i_bus.wdata & `SPM_MASK_SEL_C;
				SPM_NONE: ;
				default: begin
					for (int b = 0; b < 8; b++) begin
						if (i_bus.wdata[`SPM_DIR_LSB+b] && port_mask[pi][b]) begin
							port_nxt[pi].val[b] = i_bus.wdata[b];
						end
					end
					port_nxt[pi].dir = i_bus.wdata[15:8] & port_mask[pi][15:8];
				end
			endcase
		end
		if (i_bus.rd) begin
			case (acc)
				SPM_SEL_A: rdata_nxt = sel_a_r;
				SPM_SEL_B: rdata_nxt = sel_b_r;
				SPM_SEL_C: rdata_nxt = sel_c_r;
				SPM_NONE: rdata_nxt = 16'h0000;
				default: begin
					rdata_nxt[15:8] = port_r[pi].dir;
					for (int b = 0; b < 8; b++) begin
						rdata_nxt[b] = port_r[pi].dir[b] ? port_r[pi].val[b]
							: i_pin[pi*8+b];
					end
					rdata_nxt = rdata_nxt & port_mask[pi];
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			sel_a_r <= `SPM_RST_SEL_A;
			sel_b_r <= `SPM_RST_SEL_B;
			sel_c_r <= `SPM_RST_SEL_C;
			o_rdata <= 16'h0000;
			for (int p = 0; p < NUM_PORTS; p++) begin
				port_r[p] <= `SPM_RST_PORT;
			end
		end else begin
			sel_a_r <= sel_a_nxt;
			sel_b_r <= sel_b_nxt;
			sel_c_r <= sel_c_nxt;
			o_rdata <= rdata_nxt;
			for (int p = 0; p < NUM_PORTS; p++) begin
				port_r[p] <= port_nxt[p];
			end
		end
	end

	// reset values
	sel_c_rst_a: assert property (
		@(posedge i_core_clk) $rose(i_rstn) |-> sel_c_r == `SPM_RST_SEL_C)
		else $error("select c reset value wrong");
	sel_b_rst_a: assert property (
		@(posedge i_core_clk) $rose(i_rstn) |-> sel_b_r[0])
		else $error("port c pin 0 not strobe at reset");
	// select registers and decode
	sel_c_upper_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn) sel_c_r[15:14] == 2'h0)
		else $error("select c upper bits set");
	sel_c_write_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn) (i_bus.wr && acc == SPM_SEL_C)
		|=> sel_c_r == ($past(i_bus.wdata) & `SPM_MASK_SEL_C))
		else $error("select c write lost");
	sel_a_write_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn) (i_bus.wr && acc == SPM_SEL_A)
		|=> sel_a_r == $past(i_bus.wdata))
		else $error("select a write lost");
	unmapped_read_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn) (i_bus.rd && acc == SPM_NONE)
		|=> o_rdata == 16'h0000)
		else $error("unmapped read not zero");
	// port registers
	port_e_dir_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn) (i_bus.wr && acc == SPM_PORT_E)
		|=> port_r[4].dir == $past(i_bus.wdata[15:8]))
		else $error("port e direction write lost");
	port_f_dir_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn) (i_bus.wr && acc == SPM_PORT_F)
		|=> port_r[5].dir == ($past(i_bus.wdata[15:8]) & 8'h3f))
		else $error("port f direction write wrong");
	port_d_decode_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		(i_bus.wr && i_bus.addr == `SPM_ADDR_PORT_D)
		|=> port_r[3].dir == $past(i_bus.wdata[15:8]))
		else $error("port d write not decoded");
	port_f_mask_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn) (i_bus.rd && acc == SPM_PORT_F)
		|=> o_rdata[15:14] == 2'h0 && o_rdata[7:6] == 2'h0)
		else $error("port f unused bits read set");
	input_read_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		(i_bus.rd && acc == SPM_PORT_A && !port_r[0].dir[2])
		|=> o_rdata[2] == $past(i_pin[2]))
		else $error("input read not live");
	// pin drive and mux
	gpio_drive_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		(i_bus.wr && acc == SPM_PORT_E && !sel_c_r[1] && i_bus.wdata[9])
		|=> o_pin_oe[33] && o_pin[33] == $past(i_bus.wdata[1]))
		else $error("port e pin 1 output not driven");
	gpio_input_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		(!mux_sel[40] && !port_r[5].dir[0]) |-> !o_pin_oe[40])
		else $error("port f input pin driven");
	pin_e0_mux_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		sel_c_r[0] |-> o_pin[32] == i_periph_out[32])
		else $error("pin e0 not peripheral");
	periph_drive_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		mux_sel[40] |-> o_pin_oe[40] == i_periph_oe[40] && o_pin[40] == i_periph_out[40])
		else $error("port f pin 0 not peripheral");
	periph_in_gate_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn) (o_periph_in & ~mux_sel) == '0)
		else $error("peripheral sees gpio pin");
	unused_pins_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn) o_pin_oe[47:46] == 2'h0)
		else $error("unused port f pins driven");
endmodule : spm_gpio

// ==== test/spm_pin_env.sv ====
/*
 pin-side model: board levels meeting the block's pin drivers.
 assumes one level per pin, no pulls, block output wins where it drives.
*/
`timescale 1ns/1ns
module spm_pin_env (
	input wire logic [47:0] i_pin_out,
	input wire logic [47:0] i_pin_oe,
	input wire logic [47:0] i_ext_lvl,
	output logic [47:0] o_pin_lvl
);
	// driven pins show the block's level, others the board's
	assign o_pin_lvl = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_lvl);
endmodule : spm_pin_env

// ==== test/testbench.sv ====
/*
 self-checking bench for the pin mux / gpio block.
 assumes single-cycle bus accesses and read data registered on the read edge, checked 1 ns after it.
*/
`timescale 1ns/1ns
module testbench;
	import spm_gpio_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	spm_bus_s bus = '0;
	logic [15:0] rdata;
	logic [47:0] lvl, pout, poe, pin_in;
	logic [47:0] ext = '0, p_out = '0, p_oe = '0;
	int error_cnt = 0;
	int samples_checked = 0;
	always #2 clk = ~clk;
	spm_pin_env i_env (.i_pin_out(pout), .i_pin_oe(poe), .i_ext_lvl(ext), .o_pin_lvl(lvl));
	spm_gpio #(.NUM_PORTS(6)) i_dut (.i_core_clk(clk), .i_rstn(rstn), .i_bus(bus),
		.o_rdata(rdata), .i_pin(lvl), .o_pin(pout), .o_pin_oe(poe),
		.i_periph_out(p_out), .i_periph_oe(p_oe), .o_periph_in(pin_in));
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		bus = '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		#1;
	endtask : wr
	task automatic rdc(input string what, input logic [15:0] a, input logic [15:0] exp);
		bus = '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk);
		#1;
		chk(what, {32'h0, exp}, {32'h0, rdata});
	endtask : rdc
	task automatic idle();
		bus = '0;
		@(posedge clk);
		#1;
	endtask : idle
	task automatic t_reset();
		rdc("sel_a", 16'h7090, 16'h0000);
		rdc("sel_b", 16'h7092, 16'hfe03);
		rdc("sel_c", 16'h7094, 16'h0001);
		rdc("port_e", 16'h7095, 16'h0000);
		ext[7:0] = 8'h5a;
		rdc("port_a in", 16'h7098, 16'h005a);
		wr(16'h7091, 16'hffff);
		rdc("hole", 16'h7091, 16'h0000);
		rdc("sel_c kept", 16'h7094, 16'h0001);
	endtask : t_reset
	task automatic t_port_e();
		wr(16'h7094, 16'h0000);
		wr(16'h7095, 16'hffa5);
		idle();
		chk("e out", 48'ha5, pout[39:32]);
		chk("e oe", 48'hff, poe[39:32]);
		rdc("e back", 16'h7095, 16'hffa5);
		ext[39:32] = 8'h3c;
		wr(16'h7095, 16'h0000);
		idle();
		chk("e in oe", 48'h00, poe[39:32]);
		rdc("e in", 16'h7095, 16'h003c);
	endtask : t_port_e
	task automatic t_port_f_mux();
		wr(16'h7096, 16'hffff);
		rdc("f back", 16'h7096, 16'h3f3f);
		wr(16'h7094, 16'hffff);
		rdc("sel_c mask", 16'h7094, 16'h3fff);
		p_out[47:32] = 16'h1e96;
		p_oe[47:32] = 16'h3fff;
		idle();
		chk("mux out", 48'h1e96, pout[47:32]);
		chk("mux oe", 48'h3fff, poe[47:32]);
		chk("periph in", 48'h1e96, pin_in[47:32]);
		wr(16'h7094, 16'h0000);
		idle();
		chk("gpio out", 48'h3f, pout[47:40]);
		chk("gpio oe", 48'h3f00, poe[47:32]);
		chk("periph in gated", 48'h0, pin_in[47:32]);
	endtask : t_port_f_mux
	task automatic t_ports();
		logic [15:0] adr [4] = '{16'h7098, 16'h709a, 16'h709c, 16'h709e};
		for (int i = 0; i < 4; i++) begin
			wr(adr[i], 16'hff00 | 16'(8'h11 * (i + 1)));
			rdc("port", adr[i], 16'hff00 | 16'(8'h11 * (i + 1)));
		end
		idle();
		chk("c0 strobe oe", 48'h0, poe[16]);
		wr(16'h7092, 16'hfe02);
		idle();
		chk("c0 gpio", 48'h1, {poe[16], pout[16]} == 2'b11);
		chk("b0 gpio oe", 48'h1, poe[8]);
		wr(16'h7090, 16'h0100);
		rdc("sel_a back", 16'h7090, 16'h0100);
		chk("b0 periph oe", 48'h0, poe[8]);
	endtask : t_ports
	task automatic finish_test();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		#20000;
		error_cnt++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge clk);
		#1 rstn = 1'b1;
		t_reset();
		t_port_e();
		t_port_f_mux();
		t_ports();
		finish_test();
	end
endmodule : testbench
